// ### cfi_inject_port_select.sv
// injection groups, header handling and external host port selection
//
// Local design decisions: the address map and the plain strobed port.
`default_nettype none
// Function
// - two injection groups each carry processor frames into the core
// - injection words queue and back-pressure like the shared queue system; register writes into a full group are dropped instead
// - frames enter by register writes or through the frame dma path
// - register access engine may attach to either injection group
// - with injection header enabled, first 20 bytes are side-band header
// - one setting holds the external host port number
// - queue mask splits extraction queues between external and internal host
// - per-port enable inserts extraction header on egress
// - per-port enable makes ingress parse injection header
// - external host on any front port exchanges frames with core
// - header sits ahead of destination address, optional prefix before it
// - injection header selects analyzer or direct forwarding to destination set
// - frame may reach both internal queues and external host
// - extraction header is 20 bytes with classification and reason
// - injected frames appear received on port 11
// ----------------------------------------
// fifo
// ----------------------------------------
module cfi_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rp];
  always_ff @(posedge clk) begin
    if (reset) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule
// ----------------------------------------
// top
// ----------------------------------------
module cfi_inject_port_select
  import cfi_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [31:0]          reg_rdata,
  input  wire logic            dma_valid,
  input  wire cfi_word_t       dma_word,
  output logic                 dma_ready,
  input  wire logic            eng_valid,
  input  wire cfi_word_t       eng_word,
  output logic                 eng_ready,
  output logic                 core_valid,
  output cfi_word_t            core_word,
  input  wire logic            core_ready,
  output logic                 core_is_header,
  output logic                 core_bypass,
  output logic [NPORT-1:0]     core_dest,
  output logic [PW-1:0]        core_src_port,
  output logic                 core_group,
  input  wire logic            rx_sof,
  input  wire logic [PW-1:0]   rx_port,
  output logic                 rx_parse_header,
  output logic                 rx_from_ext_host,
  input  wire logic            tx_sof,
  input  wire logic [PW-1:0]   tx_port,
  output logic                 tx_insert_header,
  input  wire logic            xq_valid,
  input  wire logic [NQ-1:0]   xq_set,
  output logic                 xq_out_valid,
  output logic [NQ-1:0]        xq_internal,
  output logic [NQ-1:0]        xq_external,
  output logic [PW-1:0]        external_host_port
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [PW-1:0]    external_host_port_number;
  logic [NQ-1:0]    external_host_queue_mask;
  logic [NPORT-1:0] egress_extract_header_enable;
  logic [NPORT-1:0] ingress_inject_header_enable;
  logic [2:0]       inj_ctrl;
  logic [1:0]       inj_flags, overflow;
  wire sel_ext = reg_addr == A_EXT_CFG;
  wire sel_mode = reg_addr == A_PORT_MODE;
  wire sel_ctrl = reg_addr == A_INJ_CTRL;
  wire sel_flags = reg_addr == A_INJ_FLAGS;
  wire [1:0] sel_data = {reg_addr == A_INJ_DATA1, reg_addr == A_INJ_DATA0};
  wire sel_stat = reg_addr == A_STATUS;
  wire eng_grp = inj_ctrl[F_ENG_GRP];
  always_ff @(posedge clk) begin
    if (reset) begin
      external_host_port_number <= RST_EXT_PORT;
      external_host_queue_mask  <= RST_EXT_QMSK;
      egress_extract_header_enable <= RST_PORT_EN;
      ingress_inject_header_enable <= RST_PORT_EN;
      inj_ctrl  <= '0;
      inj_flags <= '0;
    end else if (reg_wr) begin
      if (sel_ext) begin
        external_host_port_number <= reg_wdata[F_EXT_PORT +: PW];
        external_host_queue_mask  <= reg_wdata[F_EXT_QMSK +: NQ];
      end
      if (sel_mode) begin
        egress_extract_header_enable <= reg_wdata[F_XTR_HDR +: NPORT];
        ingress_inject_header_enable <= reg_wdata[F_INJ_HDR +: NPORT];
      end
      if (sel_ctrl) inj_ctrl <= reg_wdata[2:0];
      if (sel_flags) inj_flags <= reg_wdata[1:0];
    end
  end
  // ----------------------------------------
  // injection groups
  // ----------------------------------------
  cfi_word_t        grp_in [2];
  logic [1:0]       grp_in_valid;
  logic [1:0]       grp_in_ready;
  logic [1:0]       grp_out_valid;
  logic [1:0]       grp_pop;
  cfi_word_t        grp_out [2];
  logic [2:0]       grp_cnt [2];
  logic [1:0]       stream_src;
  wire cfi_word_t reg_word = '{sof: inj_flags[1], eof: inj_flags[0], data: reg_wdata};
  wire eng_on = inj_ctrl[F_ENG_ENA];
  wire dma_grp = eng_on ? !eng_grp : 1'b0;
  for (genvar g = 0; g < 2; g++) begin : gen_grp
    // engine takes its chosen group, dma the other
    wire eng_here = eng_on && (eng_grp == 1'(g));
    wire s_valid = eng_here ? eng_valid & eng_ready : dma_valid & dma_ready & dma_grp == 1'(g);
    assign stream_src[g] = inj_ctrl[F_SRC_STREAM] | eng_here;
    assign grp_in_valid[g] = stream_src[g] ? s_valid : (reg_wr && sel_data[g]);
    assign grp_in[g] = !stream_src[g] ? reg_word : (eng_here ? eng_word : dma_word);
    cfi_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_q (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (grp_in_valid[g]),
      .in_ready  (grp_in_ready[g]),
      .in_data   (grp_in[g]),
      .out_valid (grp_out_valid[g]),
      .out_ready (grp_pop[g]),
      .out_data  (grp_out[g]),
      .count     (grp_cnt[g])
    );
  end
  // registered ready keeps one slot spare, so a stream push never finds its group full
  wire next_dma_ready = stream_src[dma_grp] && grp_cnt[dma_grp] <= 3'(FIFO_DEPTH - 2);
  wire next_eng_ready = eng_on && grp_cnt[eng_grp] <= 3'(FIFO_DEPTH - 2);
  // register write into full group is dropped; sticky flag, set beats clear
  wire [1:0] ovf_set = {2{reg_wr}} & sel_data & ~stream_src & ~grp_in_ready;
  wire [1:0] ovf_clr = (reg_wr && sel_stat) ? reg_wdata[1:0] : 2'b00;
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow  <= '0;
      dma_ready <= 1'b0;
      eng_ready <= 1'b0;
    end else begin
      overflow  <= ovf_set | (overflow & ~ovf_clr);
      dma_ready <= next_dma_ready;
      eng_ready <= next_eng_ready;
    end
  end
  // ----------------------------------------
  // output arbiter
  // ----------------------------------------
  logic       locked;
  logic       cur;
  logic       last;
  logic [2:0] hdr_left;
  wire out_free = !core_valid || core_ready;
  wire pick = locked ? cur : (grp_out_valid[!last] ? !last : last);
  wire take = out_free && grp_out_valid[pick];
  assign grp_pop = {take && pick, take && !pick};
  wire cfi_word_t w = grp_out[pick];
  // leading header words counted from sof on host port
  wire hdr_on = ingress_inject_header_enable[HOST_PORT];
  wire is_hdr = w.sof ? hdr_on : (hdr_left != '0);
  wire [2:0] next_hdr_left = w.sof ? (hdr_on ? HDR_WORDS - 3'h1 : 3'h0)
                             : (hdr_left != '0 ? hdr_left - 3'h1 : 3'h0);
  always_ff @(posedge clk) begin
    if (reset) begin
      core_valid <= 1'b0;
      core_word  <= '0;
      core_is_header <= 1'b0;
      core_bypass <= 1'b0;
      core_dest <= '0;
      core_src_port <= HOST_PORT;
      core_group <= 1'b0;
      locked <= 1'b0;
      cur <= 1'b0;
      last <= 1'b1;
      hdr_left <= '0;
    end else begin
      core_src_port <= HOST_PORT;
      if (take) begin
        core_valid <= 1'b1;
        core_word  <= w;
        core_group <= pick;
        core_is_header <= is_hdr;
        hdr_left <= next_hdr_left;
        // frames are not interleaved between groups
        locked <= !w.eof;
        cur <= pick;
        last <= pick;
        // first header word picks bypass and destination set
        if (w.sof) begin
          core_bypass <= hdr_on && w.data[F_BYPASS];
          core_dest <= hdr_on ? w.data[NPORT-1:0] : '0;
        end
      end else if (core_ready) begin
        core_valid <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // port header enables and host split
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_parse_header <= 1'b0;
      rx_from_ext_host <= 1'b0;
      tx_insert_header <= 1'b0;
      xq_out_valid <= 1'b0;
      xq_internal <= '0;
      xq_external <= '0;
      external_host_port <= RST_EXT_PORT;
    end else begin
      // header parse per ingress port, plain frames when clear
      if (rx_sof) begin
        rx_parse_header <= ingress_inject_header_enable[rx_port];
        // external host on any front port
        rx_from_ext_host <= rx_port == external_host_port_number;
      end
      // extraction header insertion per egress port
      if (tx_sof) tx_insert_header <= egress_extract_header_enable[tx_port];
      // mask split, both sides may receive
      xq_out_valid <= xq_valid;
      xq_internal <= xq_valid ? xq_set & ~external_host_queue_mask : '0;
      xq_external <= xq_valid ? xq_set & external_host_queue_mask : '0;
      external_host_port <= external_host_port_number;
    end
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [31:0] rd_mux =
      sel_ext ? 32'({external_host_queue_mask, 4'h0, external_host_port_number}) :
      sel_mode ? 32'({4'h0, ingress_inject_header_enable, 4'h0,
                      egress_extract_header_enable}) :
      sel_ctrl ? 32'(inj_ctrl) :
      sel_flags ? 32'(inj_flags) :
      sel_stat ? 32'({grp_cnt[1], grp_cnt[0], core_valid, locked, overflow}) :
      32'h0000_0000;
  always_ff @(posedge clk) begin
    if (reset) reg_rdata <= '0;
    else reg_rdata <= reg_rd ? rd_mux : '0;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_src11;
    @(posedge clk) disable iff (reset) core_valid |-> core_src_port == HOST_PORT;
  endproperty
  a_src11: assert property (p_src11) else $error("src port not 11");
  property p_split;
    @(posedge clk) disable iff (reset) xq_valid |=>
      (xq_external == ($past(xq_set) & external_host_queue_mask))
      && ((xq_internal | xq_external) == $past(xq_set));
  endproperty
  a_split: assert property (p_split) else $error("queue split wrong");
  property p_both;
    @(posedge clk) disable iff (reset) (xq_internal & xq_external) == '0;
  endproperty
  a_both: assert property (p_both) else $error("queue sent twice");
  property p_xtr;
    @(posedge clk) disable iff (reset) tx_sof |=>
      tx_insert_header == egress_extract_header_enable[$past(tx_port)];
  endproperty
  a_xtr: assert property (p_xtr) else $error("extract hdr enable");
  property p_inj;
    @(posedge clk) disable iff (reset) rx_sof |=>
      rx_parse_header == $past(ingress_inject_header_enable[rx_port]);
  endproperty
  a_inj: assert property (p_inj) else $error("inject hdr enable");
  property p_hdr5;
    @(posedge clk) disable iff (reset) take && w.sof && hdr_on |=>
      core_is_header && hdr_left == 3'h4;
  endproperty
  a_hdr5: assert property (p_hdr5) else $error("header length");
  property p_nohdr;
    @(posedge clk) disable iff (reset) take && w.sof && !hdr_on |=>
      !core_is_header && !core_bypass;
  endproperty
  a_nohdr: assert property (p_nohdr) else $error("header when off");
  property p_ready;
    @(posedge clk) disable iff (reset) dma_valid && dma_ready |-> grp_in_ready[dma_grp];
  endproperty
  a_ready: assert property (p_ready) else $error("dma push into full");
  property p_hold;
    @(posedge clk) disable iff (reset) core_valid && !core_ready |=>
      core_valid && $stable(core_word);
  endproperty
  a_hold: assert property (p_hold) else $error("core word dropped");
  c_g1: cover property (@(posedge clk) take && pick);
  c_byp: cover property (@(posedge clk) core_valid && core_bypass);
  c_dual: cover property (@(posedge clk) xq_internal != '0 && xq_external != '0);
  c_ovf: cover property (@(posedge clk) overflow != '0);
endmodule
`default_nettype wire

// ### cfi_pkg.sv
// package: register map, field layout and types of the injection port selector
`default_nettype none
package cfi_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int NPORT = 12;
  localparam int NQ = 8;
  localparam int PW = 4;
  localparam int FIFO_DEPTH = 4;
  localparam logic [PW-1:0] HOST_PORT = 4'hB;
  localparam logic [2:0] HDR_WORDS = 3'h5;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_EXT_CFG = 8'h00;
  localparam logic [7:0] A_PORT_MODE = 8'h04;
  localparam logic [7:0] A_INJ_CTRL = 8'h08;
  localparam logic [7:0] A_INJ_FLAGS = 8'h0C;
  localparam logic [7:0] A_INJ_DATA0 = 8'h10;
  localparam logic [7:0] A_INJ_DATA1 = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int F_EXT_PORT = 0;
  localparam int F_EXT_QMSK = 8;
  localparam int F_XTR_HDR = 0;
  localparam int F_INJ_HDR = 16;
  localparam int F_ENG_GRP = 0;
  localparam int F_ENG_ENA = 1;
  localparam int F_SRC_STREAM = 2;
  localparam int F_BYPASS = 31;
  localparam logic [PW-1:0] RST_EXT_PORT = 4'h0;
  localparam logic [NQ-1:0] RST_EXT_QMSK = 8'h00;
  localparam logic [NPORT-1:0] RST_PORT_EN = 12'h000;
  typedef struct packed {
    logic        sof;
    logic        eof;
    logic [31:0] data;
  } cfi_word_t;
  localparam int WORD_W = $bits(cfi_word_t);
endpackage
`default_nettype wire

// ### cfi_host_model.sv
// host-side frame source feeding one injection stream of the selector
`default_nettype none
module cfi_host_model
  import cfi_pkg::*;
(
  input  wire logic clk,
  output logic      valid,
  output cfi_word_t word,
  input  wire logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  initial begin
    valid = 1'b0;
    word = '0;
  end
  task automatic send(input logic [31:0] d[$], input bit slow);
    int n;
    for (int i = 0; i < d.size(); i++) begin
      valid <= 1'b1;
      word <= '{i == 0, i == d.size() - 1, d[i]};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (ready !== 1'b1 && n < 300);
      if (n >= 300) timeouts++;
      // released bus shows the inverse, so a stale word never looks valid
      if (slow) begin
        valid <= 1'b0;
        word.data <= ~d[i];
        @(posedge clk);
      end
    end
    valid <= 1'b0;
    word.data <= ~d[d.size() - 1];
  endtask
endmodule
`default_nettype wire

// ### test_cfi_inject_port_select.sv
// self-checking bench of the injection port selector
`default_nettype none
module test_cfi_inject_port_select
  import cfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    cfi_word_t   w;
    logic        grp;
    logic        hdr;
    logic        chk;
    logic        byp;
    logic [11:0] dest;
  } cfi_exp_t;
  typedef logic [31:0] cfi_dq_t[$];
  logic             clk = 1'b0;
  logic             reset, reg_wr, reg_rd, core_ready, hold_core, rd_seen, side_seen;
  logic             rx_sof, tx_sof, xq_valid, dma_valid, dma_ready, eng_valid, eng_ready;
  logic             core_valid, core_is_header, core_bypass, core_group, xq_out_valid;
  logic             rx_parse_header, rx_from_ext_host, tx_insert_header;
  logic [7:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata;
  logic [PW-1:0]    rx_port, tx_port, core_src_port, external_host_port, cfg_port;
  logic [NQ-1:0]    xq_set, xq_internal, xq_external, qmask;
  logic [NPORT-1:0] core_dest;
  logic [27:0]      pmode;
  logic [1:0]       open_f = 2'b00;
  cfi_word_t        dma_word, eng_word, core_word;
  cfi_dq_t          fa, fb;
  logic [63:0]      rd_q[$];
  logic [19:0]      side_q[$];
  cfi_exp_t         core_q[2][$];
  int               miscompares = 0;
  int               checked = 0;

  cfi_inject_port_select dut_u (
    .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dma_valid, .dma_word, .dma_ready, .eng_valid, .eng_word, .eng_ready,
    .core_valid, .core_word, .core_ready, .core_is_header, .core_bypass, .core_dest,
    .core_src_port, .core_group, .rx_sof, .rx_port, .rx_parse_header, .rx_from_ext_host,
    .tx_sof, .tx_port, .tx_insert_header, .xq_valid, .xq_set, .xq_out_valid,
    .xq_internal, .xq_external, .external_host_port
  );
  cfi_host_model dma_u (.clk, .valid(dma_valid), .word(dma_word), .ready(dma_ready));
  cfi_host_model eng_u (.clk, .valid(eng_valid), .word(eng_word), .ready(eng_ready));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) core_ready <= !hold_core && ($urandom_range(3) != 0);

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_core(input cfi_exp_t got, input cfi_exp_t exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t core word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    miscompares += dma_u.timeouts + eng_u.timeouts;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // strobes stay up between calls so no edge sees two assignments
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    rd_q.push_back({m, e});
    @(posedge clk);
  endtask
  task automatic idle();
    {reg_wr, reg_rd, rx_sof, tx_sof, xq_valid} <= '0;
    @(posedge clk);
  endtask
  task automatic side(input logic [PW-1:0] p, input logic [NQ-1:0] s);
    {rx_sof, tx_sof, xq_valid} <= 3'h7;
    rx_port <= p;
    tx_port <= p;
    xq_set <= s;
    side_q.push_back({pmode[16+p], p == cfg_port, pmode[p], 1'b1, s & ~qmask, s & qmask});
    @(posedge clk);
  endtask
  task automatic reg_frame(input logic g, input cfi_dq_t d);
    for (int i = 0; i < d.size(); i++) begin
      wr(A_INJ_FLAGS, {30'h0, i == 0, i == d.size() - 1});
      wr(g ? A_INJ_DATA1 : A_INJ_DATA0, d[i]);
    end
  endtask
  task automatic exp_frame(input logic g, input cfi_dq_t d, input bit h);
    for (int i = 0; i < d.size(); i++) begin
      core_q[g].push_back('{'{i == 0, i == d.size() - 1, d[i]}, g, h && i < HDR_WORDS, h,
                          d[0][31],
                          h ? d[0][11:0] : 12'h000});
    end
  endtask
  function automatic cfi_dq_t mk(input int n, input logic byp);
    cfi_dq_t d;
    for (int i = 0; i < n; i++) d.push_back($urandom);
    d[0][31] = byp;
    return d;
  endfunction
  task automatic drain();
    int n;
    n = 0;
    while (core_q[0].size() + core_q[1].size() != 0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      miscompares++;
      $display("[ERR] %0t core output stalled", $time);
      end_sim();
    end
  endtask

  // ------------------------------
  // output watcher
  // ------------------------------
  always @(posedge clk) begin : mon
    cfi_exp_t    e;
    logic [63:0] r;
    rd_seen <= reg_rd;
    side_seen <= rx_sof;
    if (rd_seen === 1'b1) begin
      r = rd_q.pop_front();
      cmp_val(reg_rdata & r[63:32], r[31:0]);
    end
    if (side_seen === 1'b1) begin
      cmp_val({rx_parse_header, rx_from_ext_host, tx_insert_header, xq_out_valid,
               xq_internal, xq_external}, side_q.pop_front());
    end
    if (core_valid === 1'b1 && core_ready === 1'b1) begin
      e = core_q[core_group].size() != 0 ? core_q[core_group].pop_front() : '1;
      cmp_core('{core_word, core_group, core_is_header, e.chk, e.chk ? core_bypass : e.byp,
                 e.chk ? core_dest : e.dest}, e);
      cmp_val(core_src_port, HOST_PORT);
      cmp_val(open_f[~core_group], 1'b0);
      open_f[core_group] = !core_word.eof;
    end
  end

  // ------------------------------
  // stimulus
  // ------------------------------
  initial begin
    void'($urandom(32'h7420A8D7));
    {reset, hold_core} = 2'h3;
    {reg_wr, reg_rd, rx_sof, tx_sof, xq_valid} = '0;
    {rx_port, tx_port, xq_set, reg_addr, reg_wdata} = '0;
    cfg_port = 4'($urandom_range(11));
    qmask = 8'($urandom);
    pmode = 28'($urandom) & 28'h7FF0FFF;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(A_EXT_CFG, 32'h0, 32'hFFFFFFFF);
    rd(A_PORT_MODE, 32'h0, 32'hFFFFFFFF);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    wr(A_EXT_CFG, {16'h0, qmask, 4'h0, cfg_port});
    wr(A_PORT_MODE, {4'h0, pmode});
    rd(A_EXT_CFG, {16'h0, qmask, 4'h0, cfg_port}, 32'hFFFFFFFF);
    rd(A_PORT_MODE, {4'h0, pmode}, 32'h0FFF0FFF);
    idle();
    for (int p = 0; p < NPORT; p++) side(4'(p), 8'($urandom));
    idle();
    cmp_val(external_host_port, cfg_port);
    // register injection into both groups
    wr(A_INJ_CTRL, 32'h0);
    idle();
    hold_core <= 1'b0;
    cmp_val(dma_ready, 1'b0);
    fa = mk(3, 1'b0);
    fb = mk(2, 1'b0);
    exp_frame(1'b0, fa, 1'b0);
    exp_frame(1'b1, fb, 1'b0);
    reg_frame(1'b0, fa);
    reg_frame(1'b1, fb);
    idle();
    drain();
    // stalled core: fifo plus output stage hold five, sixth is dropped
    hold_core <= 1'b1;
    fa = mk(5, 1'b0);
    exp_frame(1'b0, fa, 1'b0);
    reg_frame(1'b0, fa);
    wr(A_INJ_FLAGS, 32'h3);
    wr(A_INJ_DATA0, 32'hDEADBEEF);
    rd(A_STATUS, 32'h4D, 32'h3FF);
    wr(A_STATUS, 32'h1);
    rd(A_STATUS, 32'h4C, 32'h3FF);
    idle();
    hold_core <= 1'b0;
    drain();
    // streams with injection header, engine on group 1
    pmode[27] = 1'b1;
    wr(A_PORT_MODE, {4'h0, pmode});
    wr(A_INJ_CTRL, 32'h7);
    idle();
    hold_core <= 1'b1;
    fa = mk(8, 1'b1);
    fb = mk(6, 1'b0);
    exp_frame(1'b0, fa, 1'b1);
    exp_frame(1'b1, fb, 1'b1);
    fork
      dma_u.send(fa, 1'b0);
      eng_u.send(fb, 1'b1);
      begin
        int n;
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (!(dma_valid === 1'b1 && dma_ready === 1'b0) && n < 50);
        cmp_val(n < 50, 1'b1);
        hold_core <= 1'b0;
      end
    join
    drain();
    rd(A_STATUS, 32'h0, 32'h3FF);
    // header off: every word is plain frame data
    pmode[27] = 1'b0;
    wr(A_PORT_MODE, {4'h0, pmode});
    idle();
    fa = mk(4, 1'b1);
    exp_frame(1'b0, fa, 1'b0);
    dma_u.send(fa, 1'b1);
    drain();
    end_sim();
  end
endmodule
`default_nettype wire
